// ### rtl/mtc_tx_coding.sv
module mtc_tx_coding (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] txd,
  input wire logic tx_en,
  input wire logic tx_er,
  input wire logic full_duplex,
  input wire logic block_code_bypass_select,
  input wire logic [3:0] rx_data_in,
  input wire logic rx_valid_in,
  input wire logic rx_error_in,
  input wire logic rx_carrier_in,
  output logic tx_clk,
  output logic rx_clk,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic col,
  output logic tx_serial,
  output logic tx_nrzi,
  output logic mlt_pos,
  output logic mlt_neg
);

  // ==========================================================================
  // input synchronisers
  logic [mtc_pkg::IN_W-1:0] s1_reg, s2_reg, s3_reg, flt_reg;
  logic [mtc_pkg::IN_W-1:0] flt_next;

  always_comb begin
    for (int i = 0; i < mtc_pkg::IN_W; i++) begin
      flt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : flt_reg[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      flt_reg <= '0;
    end else begin
      s1_reg <= {block_code_bypass_select, full_duplex, tx_er, tx_en, txd};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      flt_reg <= flt_next;
    end
  end

  logic fdx_s, byp_s;
  assign fdx_s = flt_reg[mtc_pkg::IN_FDX];
  assign byp_s = flt_reg[mtc_pkg::IN_BYP];

  // ==========================================================================
  // nibble clock divider and symbol ticks
  logic [mtc_pkg::DIV_W-1:0] div_reg, div_next;
  logic clk_out_reg, clk_out_next;
  logic tick;

  always_comb begin
    div_next = (div_reg == mtc_pkg::DIV_LAST) ? '0 : div_reg + 1'b1;
    clk_out_next = (div_next < mtc_pkg::DIV_HALF);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      div_reg <= mtc_pkg::DIV_LAST;
      clk_out_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      clk_out_reg <= clk_out_next;
    end
  end

  // uneven spacing: symbol edges jitter by one mclk, average rate is exact
  assign tick = mtc_pkg::TICK_MASK[div_reg];

  // ==========================================================================
  // nibble capture and 4B5B encoder
  logic [3:0] nib_reg, nib_next;
  logic en_reg, en_next, er_reg, er_next;
  logic [mtc_pkg::SYM_W-1:0] rom_data;
  mtc_pkg::mtc_enc_st_t st_reg, st_next;
  logic [mtc_pkg::SYM_W-1:0] group;
  logic load;

  // late-period sampling (div 6 of 8) leaves room for MAC output delay plus sync latency
  always_comb begin
    nib_next = nib_reg;
    en_next = en_reg;
    er_next = er_reg;
    if (div_reg == mtc_pkg::SAMPLE_DIV) begin
      nib_next = flt_reg[mtc_pkg::IN_TXD_LSB +: 4];
      en_next = flt_reg[mtc_pkg::IN_EN];
      er_next = flt_reg[mtc_pkg::IN_ER];
    end
  end

  mtc_code_rom u_rom (
    .mclk(mclk),
    .rst_b(rst_b),
    .addr(nib_reg),
    .data(rom_data)
  );

  assign load = (div_reg == mtc_pkg::LOAD_DIV);

  always_comb begin
    st_next = st_reg;
    group = mtc_pkg::CODE_I;
    if (byp_s) begin
      group = {er_reg, nib_reg};
      st_next = mtc_pkg::MTC_ST_IDLE;
    end else begin
      case (st_reg)
        mtc_pkg::MTC_ST_IDLE: begin
          if (en_reg) begin
            group = mtc_pkg::CODE_J;
            st_next = mtc_pkg::MTC_ST_K;
          end else begin
            group = mtc_pkg::CODE_I;
          end
        end
        mtc_pkg::MTC_ST_K: begin
          if (en_reg) begin
            group = mtc_pkg::CODE_K;
            st_next = mtc_pkg::MTC_ST_DATA;
          end else begin
            group = mtc_pkg::CODE_T;
            st_next = mtc_pkg::MTC_ST_R;
          end
        end
        mtc_pkg::MTC_ST_DATA: begin
          if (en_reg) begin
            group = er_reg ? mtc_pkg::CODE_H : rom_data;
          end else begin
            group = mtc_pkg::CODE_T;
            st_next = mtc_pkg::MTC_ST_R;
          end
        end
        mtc_pkg::MTC_ST_R: begin
          group = mtc_pkg::CODE_R;
          st_next = mtc_pkg::MTC_ST_IDLE;
        end
        default: begin
          st_next = mtc_pkg::MTC_ST_IDLE;
        end
      endcase
    end
    if (!load) begin
      st_next = st_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      nib_reg <= '0;
      en_reg <= 1'b0;
      er_reg <= 1'b0;
      st_reg <= mtc_pkg::MTC_ST_IDLE;
    end else begin
      nib_reg <= nib_next;
      en_reg <= en_next;
      er_reg <= er_next;
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // scrambler, serializer, NRZI, MLT-3
  logic [mtc_pkg::SYM_W-1:0] sh_reg, sh_next;
  logic [mtc_pkg::LFSR_W-1:0] lfsr_reg, lfsr_next;
  logic key, scr_bit;
  logic ser_reg, ser_next, nrzi_reg, nrzi_next;
  logic [1:0] mlt_reg, mlt_next;
  logic pos_reg, pos_next, neg_reg, neg_next;

  assign key = lfsr_reg[mtc_pkg::LFSR_TAP_A] ^ lfsr_reg[mtc_pkg::LFSR_TAP_B];
  assign scr_bit = sh_reg[mtc_pkg::SYM_W-1] ^ key;

  always_comb begin
    sh_next = sh_reg;
    lfsr_next = lfsr_reg;
    ser_next = ser_reg;
    nrzi_next = nrzi_reg;
    mlt_next = mlt_reg;
    if (load) begin
      sh_next = group; // no tick at load, so no bit is lost
    end else if (tick) begin
      sh_next = {sh_reg[mtc_pkg::SYM_W-2:0], 1'b0};
      lfsr_next = {lfsr_reg[mtc_pkg::LFSR_W-2:0], key};
      ser_next = scr_bit;
      if (scr_bit) begin
        nrzi_next = ~nrzi_reg;
        mlt_next = mlt_reg + 2'h1;
      end
    end
    // states 0:zero 1:plus 2:zero 3:minus
    pos_next = (mlt_next == 2'h1);
    neg_next = (mlt_next == 2'h3);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sh_reg <= mtc_pkg::CODE_I;
      lfsr_reg <= mtc_pkg::LFSR_SEED;
      ser_reg <= 1'b0;
      nrzi_reg <= 1'b0;
      mlt_reg <= 2'h0;
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else begin
      sh_reg <= sh_next;
      lfsr_reg <= lfsr_next;
      ser_reg <= ser_next;
      nrzi_reg <= nrzi_next;
      mlt_reg <= mlt_next;
      pos_reg <= pos_next;
      neg_reg <= neg_next;
    end
  end

  // ==========================================================================
  // receive side of the MII, carrier and collision
  logic [3:0] rxd_reg, rxd_next;
  logic dv_reg, dv_next, rer_reg, rer_next, crs_reg, crs_next, col_reg, col_next;
  logic tx_busy;

  assign tx_busy = byp_s ? en_reg : (st_reg != mtc_pkg::MTC_ST_IDLE);

  // updated one mclk after the falling receive clock edge so the MAC sees stable data
  always_comb begin
    rxd_next = rxd_reg;
    dv_next = dv_reg;
    rer_next = rer_reg;
    if (div_reg == mtc_pkg::RX_UPD_DIV) begin
      dv_next = rx_valid_in;
      rxd_next = rx_valid_in ? rx_data_in : 4'h0;
      rer_next = rx_valid_in & rx_error_in;
    end
    crs_next = rx_carrier_in | (~fdx_s & tx_busy);
    col_next = ~fdx_s & tx_busy & rx_carrier_in;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rxd_reg <= 4'h0;
      dv_reg <= 1'b0;
      rer_reg <= 1'b0;
      crs_reg <= 1'b0;
      col_reg <= 1'b0;
    end else begin
      rxd_reg <= rxd_next;
      dv_reg <= dv_next;
      rer_reg <= rer_next;
      crs_reg <= crs_next;
      col_reg <= col_next;
    end
  end

  assign tx_clk = clk_out_reg;
  assign rx_clk = clk_out_reg;
  assign rxd = rxd_reg;
  assign rx_dv = dv_reg;
  assign rx_er = rer_reg;
  assign crs = crs_reg;
  assign col = col_reg;
  assign tx_serial = ser_reg;
  assign tx_nrzi = nrzi_reg;
  assign mlt_pos = pos_reg;
  assign mlt_neg = neg_reg;

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_clk_period: assert property ($rose(clk_out_reg) |-> ##8 $rose(clk_out_reg))
    else $error("transmit clock period not eight cycles");
  a_jk_start: assert property (load && !byp_s && st_reg == mtc_pkg::MTC_ST_IDLE && en_reg
    |=> sh_reg == mtc_pkg::CODE_J ##8 (sh_reg == mtc_pkg::CODE_K || sh_reg == mtc_pkg::CODE_T))
    else $error("frame start not J then K");
  a_err_symbol: assert property (load && !byp_s && st_reg == mtc_pkg::MTC_ST_DATA && en_reg && er_reg
    |=> sh_reg == mtc_pkg::CODE_H)
    else $error("error nibble not replaced by invalid symbol");
  a_tr_end: assert property (load && !byp_s && st_reg == mtc_pkg::MTC_ST_DATA && !en_reg
    |=> sh_reg == mtc_pkg::CODE_T ##8 sh_reg == mtc_pkg::CODE_R)
    else $error("frame end not T then R");
  a_idle_fill: assert property (load && !byp_s && st_reg == mtc_pkg::MTC_ST_IDLE && !en_reg
    |=> sh_reg == mtc_pkg::CODE_I)
    else $error("idle not sent between frames");
  a_nrzi_toggle: assert property (tick && !load |=> (nrzi_reg != $past(nrzi_reg)) == ser_reg)
    else $error("nrzi does not follow serial bit");
  a_mlt_excl: assert property (!(pos_reg && neg_reg) and ($rose(pos_reg) |-> !neg_reg))
    else $error("both drive streams active");
  a_col_fdx: assert property (fdx_s && $past(fdx_s) |-> !col_reg)
    else $error("collision in full duplex");
  a_crs_rx: assert property (rx_carrier_in |=> crs_reg)
    else $error("carrier missing during receive");
  a_rx_nibble: assert property (div_reg == mtc_pkg::RX_UPD_DIV && rx_valid_in
    |=> dv_reg && rxd_reg == $past(rx_data_in) ##1 (dv_reg && $stable(rxd_reg)) [*7])
    else $error("receive nibble not held for a period");

endmodule : mtc_tx_coding

// ### rtl/mtc_pkg.sv
package mtc_pkg;

  // ==========================================================================
  // timing
  localparam int MCLK_PERIOD_NS = 5;
  localparam int TXCLK_PERIOD_NS = 40;
  localparam int NIB_CYCLES = TXCLK_PERIOD_NS / MCLK_PERIOD_NS;
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(NIB_CYCLES - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(NIB_CYCLES / 2);
  localparam logic [DIV_W-1:0] LOAD_DIV = 3'h0;
  localparam logic [DIV_W-1:0] SAMPLE_DIV = 3'h6;
  localparam logic [DIV_W-1:0] RX_UPD_DIV = 3'h4;
  // five symbol bits per nibble period: 125 Msym/s from 200 MHz
  localparam logic [7:0] TICK_MASK = 8'hDA;

  // ==========================================================================
  // code groups
  localparam int NIB_W = 4;
  localparam int SYM_W = 5;
  localparam logic [SYM_W-1:0] CODE_J = 5'h18;
  localparam logic [SYM_W-1:0] CODE_K = 5'h11;
  localparam logic [SYM_W-1:0] CODE_T = 5'h0D;
  localparam logic [SYM_W-1:0] CODE_R = 5'h07;
  localparam logic [SYM_W-1:0] CODE_I = 5'h1F;
  localparam logic [SYM_W-1:0] CODE_H = 5'h04;

  // ==========================================================================
  // scrambler
  localparam int LFSR_W = 11;
  localparam int LFSR_TAP_A = 10;
  localparam int LFSR_TAP_B = 8;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 11'h7FF;

  // ==========================================================================
  // input sync vector layout
  localparam int IN_W = 8;
  localparam int IN_TXD_LSB = 0;
  localparam int IN_EN = 4;
  localparam int IN_ER = 5;
  localparam int IN_FDX = 6;
  localparam int IN_BYP = 7;

  typedef enum logic [1:0] {
    MTC_ST_IDLE,
    MTC_ST_K,
    MTC_ST_DATA,
    MTC_ST_R
  } mtc_enc_st_t;

endpackage : mtc_pkg

// ### rtl/mtc_code_rom.sv
module mtc_code_rom (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [mtc_pkg::NIB_W-1:0] addr,
  output logic [mtc_pkg::SYM_W-1:0] data
);

  logic [mtc_pkg::SYM_W-1:0] data_reg;
  logic [mtc_pkg::SYM_W-1:0] data_next;

  function automatic logic [mtc_pkg::SYM_W-1:0] code_of(input logic [mtc_pkg::NIB_W-1:0] n);
    case (n)
      4'h0: code_of = 5'h1E;
      4'h1: code_of = 5'h09;
      4'h2: code_of = 5'h14;
      4'h3: code_of = 5'h15;
      4'h4: code_of = 5'h0A;
      4'h5: code_of = 5'h0B;
      4'h6: code_of = 5'h0E;
      4'h7: code_of = 5'h0F;
      4'h8: code_of = 5'h12;
      4'h9: code_of = 5'h13;
      4'hA: code_of = 5'h16;
      4'hB: code_of = 5'h17;
      4'hC: code_of = 5'h1A;
      4'hD: code_of = 5'h1B;
      4'hE: code_of = 5'h1C;
      default: code_of = 5'h1D;
    endcase
  endfunction : code_of

  always_comb begin
    data_next = code_of(addr);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      data_reg <= mtc_pkg::CODE_I;
    end else begin
      data_reg <= data_next;
    end
  end

  assign data = data_reg;

endmodule : mtc_code_rom

// ### verif/mtc_mac_model.sv
// ============================================================
// reconciliation side of the transmit nibble interface
module mtc_mac_model (
  input wire logic mclk,
  input wire logic tx_clk,
  input wire logic [3:0] nib_in,
  input wire logic en_in,
  input wire logic er_in,
  output logic [3:0] txd,
  output logic tx_en,
  output logic tx_er,
  output logic took
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen = 1'b0;
  initial begin
    txd = 4'h0;
    tx_en = 1'b0;
    tx_er = 1'b0;
    took = 1'b0;
  end
  // launch just after the clock rises so the phy samples a settled nibble
  always @(negedge mclk) begin
    seen <= tx_clk;
    took <= tx_clk && !seen;
    if (tx_clk && !seen) begin
      txd <= nib_in;
      tx_en <= en_in;
      tx_er <= er_in;
    end
  end
endmodule : mtc_mac_model

// ### verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] TBL [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                      5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] txd, rxd, nib_in = 4'hF, rx_data_in = 4'h0;
  logic tx_en, tx_er, took, en_in = 1'b0, er_in = 1'b1, fdx = 1'b0, byp = 1'b0;
  logic rx_valid_in = 1'b0, rx_error_in = 1'b0, rx_carrier_in = 1'b0;
  logic tx_clk, rx_clk, rx_dv, rx_er, crs, col, tx_serial, tx_nrzi, mlt_pos, mlt_neg;
  int num_errors = 0, cmp_count = 0, seed = 32'h218003bb, cyc = 0;
  int div = 0, ones = 0, tog = 0, mch = 0, ph = 0;
  logic tx_prev = 1'b0, nrzi_prev = 1'b0, in_frame = 1'b0, last_pos = 1'b0, key;
  logic [1:0] mlt_prev = 2'h0;
  logic [10:0] key_sr = 11'h000;
  logic [4:0] sh = 5'h00;
  logic [4:0] exp_q[$];

  mtc_mac_model i_mac (.mclk(mclk), .tx_clk(tx_clk), .nib_in(nib_in), .en_in(en_in), .er_in(er_in),
    .txd(txd), .tx_en(tx_en), .tx_er(tx_er), .took(took));
  mtc_tx_coding i_dut (.mclk(mclk), .rst_b(rst_b), .txd(txd), .tx_en(tx_en), .tx_er(tx_er),
    .full_duplex(fdx), .block_code_bypass_select(byp), .rx_data_in(rx_data_in),
    .rx_valid_in(rx_valid_in), .rx_error_in(rx_error_in), .rx_carrier_in(rx_carrier_in),
    .tx_clk(tx_clk), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs),
    .col(col), .tx_serial(tx_serial), .tx_nrzi(tx_nrzi), .mlt_pos(mlt_pos), .mlt_neg(mlt_neg));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  // ============================================================
  // checking helpers
  task automatic chk_sig(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : chk_sig

  task automatic chk_vec(input logic [4:0] got, input logic [4:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_vec

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  function automatic logic [4:0] exp_group(input logic [3:0] n, input logic r, input int i, input logic b);
    if (b) return {r, n};
    if (i == 0) return 5'h18;
    if (i == 1) return 5'h11;
    return r ? 5'h04 : TBL[n];
  endfunction : exp_group

  // ============================================================
  // line monitor and receive stimulus
  always @(negedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      complete_run();
    end
    div = (tx_clk && !tx_prev) ? 0 : div + 1;
    tx_prev = tx_clk;
    if (rst_b && cyc > 12 && div < 8) begin
      chk_sig(rx_clk, tx_clk, "rx clock");
      chk_sig(tx_clk, div < 4, "tx clock");
      if (mtc_pkg::TICK_MASK[div]) begin
        ones += int'(tx_serial);
        // idle groups are all ones, so the key is learnt from the line before checking
        key = (cyc < 200) ? ~tx_serial : key_sr[10] ^ key_sr[8];
        key_sr = {key_sr[9:0], key};
        sh = {sh[3:0], tx_serial ^ key};
        // the last bit of a group is launched on the edge that opens the next period
        if (div == 1 && cyc >= 200) begin
          if (!in_frame && sh !== 5'h1F) in_frame = 1'b1;
          if (in_frame) begin
            chk_vec(sh, exp_q.size() > 0 ? exp_q.pop_front() : 5'h1F, "code group");
            in_frame = exp_q.size() > 0;
          end
        end
      end
      tog += int'(tx_nrzi != nrzi_prev);
      nrzi_prev = tx_nrzi;
      mch += int'({mlt_pos, mlt_neg} != mlt_prev);
      chk_sig(mlt_pos & mlt_neg, 1'b0, "mlt both");
      if (mlt_pos && !mlt_prev[1]) begin
        chk_sig(last_pos, 1'b0, "mlt order");
        last_pos = 1'b1;
      end
      if (mlt_neg && !mlt_prev[0]) begin
        chk_sig(last_pos, 1'b1, "mlt order");
        last_pos = 1'b0;
      end
      mlt_prev = {mlt_pos, mlt_neg};
      if (div == 0) begin
        {rx_carrier_in, rx_error_in, rx_valid_in, rx_data_in} = 7'($random(seed));
      end
      if (div == 7 && cyc > 30) begin
        chk_vec({1'b0, rxd}, {1'b0, rx_valid_in ? rx_data_in : 4'h0}, "rxd");
        chk_sig(rx_dv, rx_valid_in, "rx valid");
        chk_sig(rx_er, rx_error_in & rx_valid_in, "rx error");
        if (ph != 0) begin
          chk_sig(crs, rx_carrier_in | (ph == 2 && !fdx), "carrier");
          chk_sig(col, ph == 2 && !fdx && rx_carrier_in, "collision");
        end
      end
    end
  end

  // ============================================================
  // transmit stimulus
  task automatic put(input logic [3:0] n, input logic e, input logic r);
    nib_in = n;
    en_in = e;
    er_in = r;
    @(posedge took);
  endtask : put

  task automatic idle(input int n);
    repeat (n) put(4'hF, 1'b0, 1'b1);
  endtask : idle

  task automatic send_frame(input int len, input int erpos, input string name);
    logic [3:0] n;
    logic r;
    ph = 0;
    for (int i = 0; i < len; i++) begin
      n = 4'($random(seed));
      r = (i == erpos);
      exp_q.push_back(exp_group(n, r, i, byp));
      put(n, 1'b1, r);
      ph = (i >= 3 && i < len - 1) ? 2 : 0;
    end
    if (!byp) begin
      exp_q.push_back(5'h0D);
      exp_q.push_back(5'h07);
    end
    exp_q.push_back(5'h1F);
    idle(12);
    ph = 1;
    idle(3);
    chk_sig(exp_q.size() == 0, 1'b1, "frame drained");
    $display("test %s done", name);
  endtask : send_frame

  initial begin
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    idle(40);
    send_frame(1, -1, "single nibble");
    send_frame(2, -1, "two nibbles");
    for (int k = 0; k < 6; k++) begin
      send_frame(3 + {$random(seed)} % 20, 2 + k, "random frame");
    end
    fdx = 1'b1;
    idle(4);
    send_frame(10, -1, "full duplex");
    fdx = 1'b0;
    byp = 1'b1;
    idle(4);
    send_frame(8, 3, "bypass");
    byp = 1'b0;
    idle(4);
    send_frame(16, 5, "after bypass");
    chk_sig((ones > tog ? ones - tog : tog - ones) <= 2, 1'b1, "nrzi count");
    chk_sig((mch > tog ? mch - tog : tog - mch) <= 2, 1'b1, "mlt count");
    complete_run();
  end
endmodule : testbench
